// ---- inc/rx_mon_pkg.sv ----
package rx_mon_pkg;
    // ****************************************
    // widths and counts
    // ****************************************
    localparam int unsigned CNT_W_SHORT = 16;
    localparam int unsigned CNT_W_LONG = 24;
    localparam int unsigned NUM_CNT = 11;
    localparam int unsigned HADDR_W = 10;
    localparam int unsigned RAM_AW = 9;
    localparam int unsigned RAM_DEPTH = 512;
    localparam int unsigned ROW_LEN = 40;
    localparam int unsigned TOH_LEN = 36;
    localparam int unsigned NUM_ROWS = 9;
    localparam int unsigned TRACE_LEN = 64;

    // ****************************************
    // counter indexes, also status bit positions
    // ****************************************
    localparam int unsigned IX_B1_CV = 0;
    localparam int unsigned IX_B2_CV = 1;
    localparam int unsigned IX_B3_CV = 2;
    localparam int unsigned IX_B1_BE = 3;
    localparam int unsigned IX_B2_BE = 4;
    localparam int unsigned IX_B3_BE = 5;
    localparam int unsigned IX_LFEBE = 6;
    localparam int unsigned IX_PFEBE = 7;
    localparam int unsigned IX_OCELL = 8;
    localparam int unsigned IX_DCELL = 9;
    localparam int unsigned IX_SERR = 10;
    localparam int unsigned IX_MERR = 11;
    localparam int unsigned NUM_ALL = 12;

    // ****************************************
    // host address map
    // ****************************************
    localparam logic [9:0] CNT_BASE = 10'h100;
    localparam logic [9:0] RAM_BASE = 10'h200;
    localparam logic [9:0] TRACE_BASE = 10'h380;
    localparam logic [9:0] CNT_SPAN = 10'h036;
    localparam logic [9:0] LOW_RATE_STEP = 10'h004;
    // low byte offset of each counter inside the counter region
    localparam logic [9:0] CNT_OFS [NUM_ALL] = '{10'h000, 10'h004, 10'h00a, 10'h00e,
        10'h012, 10'h016, 10'h01a, 10'h020, 10'h024, 10'h02a, 10'h030, 10'h034};
    localparam bit CNT_LONG [NUM_ALL] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0,
        1'b1, 1'b1, 1'b0, 1'b0};

    // drop configuration codes
    localparam logic [1:0] DROP_IDLE = 2'h1;
    localparam logic [1:0] DROP_UNASSIGNED = 2'h2;
endpackage : rx_mon_pkg

// ---- src/ovh_ram.sv ----
`timescale 1ns/1ps
// ****************************************
// receive overhead storage, registered read
// ****************************************
module ovh_ram (
    input wire logic clk_in,
    input wire logic wr_en_in,
    input wire logic [8:0] wr_addr_in,
    input wire logic [7:0] wr_data_in,
    input wire logic [8:0] rd_addr_in,
    output logic [7:0] rd_data_out
);
    logic [7:0] mem [rx_mon_pkg::RAM_DEPTH];

    // write port and registered read port
    always_ff @(posedge clk_in) begin
        if (wr_en_in) begin
            mem[wr_addr_in] <= wr_data_in;
        end
        rd_data_out <= mem[rd_addr_in];
    end
endmodule : ovh_ram

// ---- src/rx_perf_counters_overhead_ram.sv ----
`timescale 1ns/1ps
// Overview of operation
// - coding-violation counters add the number of errored B1/B2/B3 parity bits.
// - block-error counters add one per frame with any B1/B2/B3 error.
// - line far-end counter adds count from third Z2 byte.
// - path far-end counter adds G1 bits 1 to 4.
// - output cell counter counts cells written to output FIFO only.
// - discarded counter counts idle and/or unassigned drops per drop configuration.
// - single-error counter counts cells with exactly one header bit error.
// - multiple-error counter counts cells with more than one header bit error.
// - counter rolling over past maximum sets its status bit, which raises interrupt.
// - counters wrap on passing maximum, keeping the excess; a step of one from maximum gives zero.
// - each received overhead byte is stored in RAM from address 200.
// - RAM holds 324 transport plus 36 path overhead bytes.
// - D1-D12 and E1/E2 bytes also go out the serial port.
// - low rate select uses every fourth address, A1 at 200, 204, 208.
// - counters are 16 bits, line far-end, output and discarded 24 bits.
// - counters reset to zero, host writable, unchanged by reads.
// - J1 bytes fill 64 trace locations in turn, then wrap.
module rx_perf_counters_overhead_ram (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic low_rate_select_in,
    // parity results, one pulse per frame
    input wire logic chk_valid_in,
    input wire logic [7:0] b1_err_bits_in,
    input wire logic [7:0] b2_err_bits_in,
    input wire logic [7:0] b3_err_bits_in,
    input wire logic [7:0] z2_febe_in,
    input wire logic [7:0] g1_byte_in,
    // cell events, one pulse each
    input wire logic cell_to_fifo_in,
    input wire logic idle_drop_in,
    input wire logic unassigned_drop_in,
    input wire logic [1:0] drop_cfg_in,
    input wire logic hdr_one_err_in,
    input wire logic hdr_multi_err_in,
    // overhead byte stream
    input wire logic ovh_valid_in,
    input wire logic [3:0] ovh_row_in,
    input wire logic [5:0] ovh_col_in,
    input wire logic ovh_is_dcc_in,
    input wire logic ovh_is_j1_in,
    input wire logic [7:0] ovh_byte_in,
    // host access
    input wire logic host_rd_in,
    input wire logic host_wr_in,
    input wire logic [9:0] host_addr_in,
    input wire logic [7:0] host_wdata_in,
    input wire logic status_clr_in,
    output logic [7:0] host_rdata_out,
    output logic [11:0] status_out,
    output logic irq_out,
    output logic dcc_valid_out,
    output logic [7:0] dcc_data_out
);
    localparam int unsigned N = rx_mon_pkg::NUM_ALL;
    localparam int unsigned LW = rx_mon_pkg::CNT_W_LONG;

    // ****************************************
    // counter increments
    // ****************************************
    function automatic logic [3:0] ones(input logic [7:0] v);
        logic [3:0] s;
        s = 4'h0;
        for (int i = 0; i < 8; i++) begin
            s = s + {3'h0, v[i]};
        end
        return s;
    endfunction : ones

    logic [LW-1:0] inc [N];
    logic drop_hit;
    assign drop_hit = (idle_drop_in && (drop_cfg_in & rx_mon_pkg::DROP_IDLE) != 2'h0)
        || (unassigned_drop_in && (drop_cfg_in & rx_mon_pkg::DROP_UNASSIGNED) != 2'h0);
    assign inc[rx_mon_pkg::IX_B1_CV] = chk_valid_in ? {20'h0, ones(b1_err_bits_in)} : 24'h0;
    assign inc[rx_mon_pkg::IX_B2_CV] = chk_valid_in ? {20'h0, ones(b2_err_bits_in)} : 24'h0;
    assign inc[rx_mon_pkg::IX_B3_CV] = chk_valid_in ? {20'h0, ones(b3_err_bits_in)} : 24'h0;
    assign inc[rx_mon_pkg::IX_B1_BE] = {23'h0, chk_valid_in && b1_err_bits_in != 8'h0};
    assign inc[rx_mon_pkg::IX_B2_BE] = {23'h0, chk_valid_in && b2_err_bits_in != 8'h0};
    assign inc[rx_mon_pkg::IX_B3_BE] = {23'h0, chk_valid_in && b3_err_bits_in != 8'h0};
    assign inc[rx_mon_pkg::IX_LFEBE] = chk_valid_in ? {16'h0, z2_febe_in} : 24'h0;
    assign inc[rx_mon_pkg::IX_PFEBE] = chk_valid_in ? {20'h0, g1_byte_in[7:4]} : 24'h0;
    assign inc[rx_mon_pkg::IX_OCELL] = {23'h0, cell_to_fifo_in};
    assign inc[rx_mon_pkg::IX_DCELL] = {23'h0, drop_hit};
    assign inc[rx_mon_pkg::IX_SERR] = {23'h0, hdr_one_err_in};
    assign inc[rx_mon_pkg::IX_MERR] = {23'h0, hdr_multi_err_in};

    // ****************************************
    // counters with byte-wide host access
    // ****************************************
    logic [LW-1:0] cnt_r [N];
    logic [N-1:0] wrap_ev;
    logic [7:0] cnt_rd [N];
    logic [N-1:0] cnt_sel;
    logic [9:0] cnt_rel;
    assign cnt_rel = host_addr_in - rx_mon_pkg::CNT_BASE;

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : gen_cnt
            localparam int unsigned W = rx_mon_pkg::CNT_LONG[g] ? rx_mon_pkg::CNT_W_LONG
                : rx_mon_pkg::CNT_W_SHORT;
            localparam int unsigned NB = W / 8;
            logic [W:0] sum;
            logic [9:0] lane;
            logic [W-1:0] cnt_nxt;
            logic [W-1:0] cur;
            assign cur = cnt_r[g][W-1:0];
            assign lane = cnt_rel - rx_mon_pkg::CNT_OFS[g];
            assign cnt_sel[g] = cnt_rel >= rx_mon_pkg::CNT_OFS[g]
                && lane < 10'(NB) && host_addr_in >= rx_mon_pkg::CNT_BASE;
            assign sum = {1'b0, cur} + (W + 1)'(inc[g]);
            assign cnt_rd[g] = cnt_sel[g] ? 8'(cur >> {lane[1:0], 3'h0}) : 8'h00;
            // crossing the top wraps around, keeping the excess over the maximum, rather than sticking
            always_comb begin
                cnt_nxt = sum[W-1:0];
                if (host_wr_in && cnt_sel[g]) begin
                    cnt_nxt = cur;
                    cnt_nxt[lane[1:0]*8 +: 8] = host_wdata_in;
                end
            end
            // counter register, cleared by reset, untouched by reads
            always_ff @(posedge clk_in or posedge rst_in) begin
                if (rst_in) begin
                    cnt_r[g] <= '0;
                end else begin
                    cnt_r[g] <= LW'(cnt_nxt);
                end
            end
            // rollover through the maximum marks the counter
            assign wrap_ev[g] = sum[W] && !(host_wr_in && cnt_sel[g]);
        end
    endgenerate

    // ****************************************
    // status and interrupt
    // ****************************************
    logic [N-1:0] status_r;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            status_r <= '0;
        end else begin
            status_r <= (status_clr_in ? '0 : status_r) | wrap_ev;
        end
    end
    assign status_out = status_r;
    assign irq_out = |status_r;

    // ****************************************
    // overhead RAM write address
    // ****************************************
    logic [5:0] trace_ptr_r;
    logic [8:0] row_base;
    logic [8:0] grid_idx;
    logic [8:0] toh_addr;
    logic [8:0] ram_waddr;
    assign row_base = 9'(ovh_row_in * rx_mon_pkg::ROW_LEN);
    assign grid_idx = low_rate_select_in
        ? 9'(ovh_col_in * rx_mon_pkg::LOW_RATE_STEP) : 9'(ovh_col_in);
    assign toh_addr = row_base + grid_idx;
    assign ram_waddr = ovh_is_j1_in ? 9'(rx_mon_pkg::TRACE_BASE - rx_mon_pkg::RAM_BASE)
        + {3'h0, trace_ptr_r} : toh_addr;

    // path trace pointer steps per J1
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            trace_ptr_r <= 6'h00;
        end else if (ovh_valid_in && ovh_is_j1_in) begin
            trace_ptr_r <= trace_ptr_r + 6'h01;
        end
    end

    // serial comms bytes copied out alongside storage
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            dcc_valid_out <= 1'b0;
            dcc_data_out <= 8'h00;
        end else begin
            dcc_valid_out <= ovh_valid_in && ovh_is_dcc_in;
            dcc_data_out <= (ovh_valid_in && ovh_is_dcc_in) ? ovh_byte_in : dcc_data_out;
        end
    end

    // ****************************************
    // host read path
    // ****************************************
    logic [7:0] ram_rdata;
    logic ram_sel_r;
    logic [7:0] cnt_rd_r;
    logic [7:0] cnt_or;
    logic [8:0] ram_raddr;
    assign ram_raddr = 9'(host_addr_in - rx_mon_pkg::RAM_BASE);
    always_comb begin
        cnt_or = 8'h00;
        for (int i = 0; i < N; i++) begin
            cnt_or = cnt_or | cnt_rd[i];
        end
    end

    ovh_ram u_ram (
        .clk_in(clk_in),
        .wr_en_in(ovh_valid_in),
        .wr_addr_in(ram_waddr),
        .wr_data_in(ovh_byte_in),
        .rd_addr_in(ram_raddr),
        .rd_data_out(ram_rdata)
    );

    // read data registered one cycle after the strobe
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ram_sel_r <= 1'b0;
            cnt_rd_r <= 8'h00;
        end else if (host_rd_in) begin
            ram_sel_r <= host_addr_in >= rx_mon_pkg::RAM_BASE;
            cnt_rd_r <= cnt_or;
        end
    end
    assign host_rdata_out = ram_sel_r ? ram_rdata : cnt_rd_r;

    // ****************************************
    // checks
    // ****************************************
    chk_wrap_sets_status: assert property (@(posedge clk_in) disable iff (rst_in)
        wrap_ev[rx_mon_pkg::IX_SERR] |=> status_r[rx_mon_pkg::IX_SERR] && irq_out)
        else $error("wrap did not raise status");
    chk_serr_step: assert property (@(posedge clk_in) disable iff (rst_in)
        hdr_one_err_in && !host_wr_in |=> cnt_r[rx_mon_pkg::IX_SERR][15:0]
        == $past(cnt_r[rx_mon_pkg::IX_SERR][15:0]) + 16'h0001)
        else $error("single error count step wrong");
    chk_trace_wrap: assert property (@(posedge clk_in) disable iff (rst_in)
        ovh_valid_in && ovh_is_j1_in && trace_ptr_r == 6'h3f |=> trace_ptr_r == 6'h00)
        else $error("trace pointer did not wrap");
    chk_dcc_copy: assert property (@(posedge clk_in) disable iff (rst_in)
        ovh_valid_in && ovh_is_dcc_in |=> dcc_valid_out && dcc_data_out == $past(ovh_byte_in))
        else $error("comms byte not forwarded");
    chk_ocell_step: assert property (@(posedge clk_in) disable iff (rst_in)
        cell_to_fifo_in && !host_wr_in |=> cnt_r[rx_mon_pkg::IX_OCELL]
        == $past(cnt_r[rx_mon_pkg::IX_OCELL]) + 24'h000001)
        else $error("output cell count step wrong");
    chk_clr_empties: assert property (@(posedge clk_in) disable iff (rst_in)
        status_clr_in && wrap_ev == '0 |=> status_r == '0 && !irq_out)
        else $error("status clear left bits set");
endmodule : rx_perf_counters_overhead_ram

// ---- test/host_model.sv ----
`timescale 1ns/1ps
// ****************************************
// host controller model on the access port
// ****************************************
module host_model (
    input wire logic clk_in,
    output logic rd_out,
    output logic wr_out,
    output logic [9:0] addr_out,
    output logic [7:0] wdata_out,
    input wire logic [7:0] rdata_in
);
    // idle: no strobe, address and data show junk
    initial begin
        rd_out = 1'b0;
        wr_out = 1'b0;
        addr_out = 10'h3ff;
        wdata_out = 8'h5a;
    end
    // one write, held to the taking edge, then released to junk
    task automatic write_byte(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk_in);
        #1;
        wr_out = 1'b1;
        addr_out = a;
        wdata_out = d;
        @(posedge clk_in);
        #1;
        wr_out = 1'b0;
        addr_out = ~a;
        wdata_out = ~d;
    endtask : write_byte
    // one read, data registered at the taking edge
    task automatic read_byte(input logic [9:0] a, output logic [7:0] d);
        @(posedge clk_in);
        #1;
        rd_out = 1'b1;
        addr_out = a;
        @(posedge clk_in);
        #1;
        rd_out = 1'b0;
        addr_out = ~a;
        d = rdata_in;
    endtask : read_byte
endmodule : host_model

// ---- test/tb.sv ----
`timescale 1ns/1ps
module tb;
    logic clk_in, rst_in, low_rate_select_in, chk_valid_in, cell_to_fifo_in, idle_drop_in;
    logic unassigned_drop_in, hdr_one_err_in, hdr_multi_err_in, ovh_valid_in, ovh_is_dcc_in;
    logic ovh_is_j1_in, host_rd_in, host_wr_in, status_clr_in, irq_out, dcc_valid_out;
    logic [7:0] b1_err_bits_in, b2_err_bits_in, b3_err_bits_in, z2_febe_in, g1_byte_in;
    logic [7:0] ovh_byte_in, host_wdata_in, host_rdata_out, dcc_data_out, d;
    logic [1:0] drop_cfg_in;
    logic [3:0] ovh_row_in;
    logic [5:0] ovh_col_in;
    logic [9:0] host_addr_in;
    logic [11:0] status_out, exp_status;
    logic [31:0] rnd;
    int failures, samples_checked, row, col, exp_cnt [12];
    logic [7:0] exp_ram [int];
    // event vectors that bump each counter once
    localparam logic [31:0] bump_tab [12] = '{32'h0000_0101, 32'h0001_0001, 32'h0100_0001,
        32'h0000_0101, 32'h0001_0001, 32'h0100_0001, 32'h0000_0101, 32'h0010_0001,
        32'h0000_0002, 32'h0000_000c, 32'h0000_0020, 32'h0000_0040};

    rx_perf_counters_overhead_ram dut (.clk_in, .rst_in, .low_rate_select_in, .chk_valid_in,
        .b1_err_bits_in, .b2_err_bits_in, .b3_err_bits_in, .z2_febe_in, .g1_byte_in,
        .cell_to_fifo_in, .idle_drop_in, .unassigned_drop_in, .drop_cfg_in, .hdr_one_err_in,
        .hdr_multi_err_in, .ovh_valid_in, .ovh_row_in, .ovh_col_in, .ovh_is_dcc_in,
        .ovh_is_j1_in, .ovh_byte_in, .host_rd_in, .host_wr_in, .host_addr_in, .host_wdata_in,
        .status_clr_in, .host_rdata_out, .status_out, .irq_out, .dcc_valid_out, .dcc_data_out);
    host_model host (.clk_in, .rd_out(host_rd_in), .wr_out(host_wr_in),
        .addr_out(host_addr_in), .wdata_out(host_wdata_in), .rdata_in(host_rdata_out));

    // ****************************************
    // helpers and reference model
    // ****************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("FAIL at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic add(input int i, input int n);
        int top;
        top = rx_mon_pkg::CNT_LONG[i] ? 32'hffffff : 32'hffff;
        exp_cnt[i] += n;
        if (exp_cnt[i] > top) begin
            exp_cnt[i] -= top + 1;
            exp_status[i] = 1'b1;
        end
    endtask : add
    // one cycle of events, model updated alongside
    task automatic drive(input logic [31:0] r);
        @(posedge clk_in);
        #1;
        chk_valid_in = r[0];
        cell_to_fifo_in = r[2:1] == 2'h1;
        idle_drop_in = r[2:1] == 2'h2;
        unassigned_drop_in = r[2:1] == 2'h3;
        drop_cfg_in = r[4:3];
        hdr_one_err_in = r[6:5] == 2'h1;
        hdr_multi_err_in = r[6:5] == 2'h2;
        {b3_err_bits_in, b2_err_bits_in, b1_err_bits_in} = r[31:8];
        z2_febe_in = r[15:8] ^ r[31:24];
        g1_byte_in = r[23:16];
        for (int k = 0; k < 3 && r[0]; k++) begin
            add(k, $countones(r[8*k+8 +: 8]));
            add(k + 3, int'(r[8*k+8 +: 8] != 8'h00));
        end
        add(6, r[0] ? int'(z2_febe_in) : 0);
        add(7, r[0] ? int'(r[23:20]) : 0);
        add(8, int'(cell_to_fifo_in));
        add(9, int'((idle_drop_in && r[3]) || (unassigned_drop_in && r[4])));
        add(10, int'(hdr_one_err_in));
        add(11, int'(hdr_multi_err_in));
    endtask : drive
    task automatic read_cnt(input int i, output logic [31:0] r);
        logic [7:0] b;
        r = 32'h0;
        for (int k = 0; k < (rx_mon_pkg::CNT_LONG[i] ? 3 : 2); k++) begin
            host.read_byte(rx_mon_pkg::CNT_BASE + rx_mon_pkg::CNT_OFS[i] + 10'(k), b);
            r[8*k +: 8] = b;
        end
    endtask : read_cnt
    task automatic check_all();
        logic [31:0] r;
        for (int i = 0; i < 12; i++) begin
            read_cnt(i, r);
            check(r, 32'(exp_cnt[i]));
        end
        check({20'h0, status_out}, {20'h0, exp_status});
        check({31'h0, irq_out}, {31'h0, |exp_status});
    endtask : check_all
    // one overhead byte, serial copy looked at in the cycle after
    task automatic ovh(input int r, input int c, input logic lr, input logic j, input logic [7:0] b);
        @(posedge clk_in);
        #1;
        {ovh_valid_in, low_rate_select_in, ovh_is_j1_in, ovh_is_dcc_in} = {1'b1, lr, j, b[0]};
        ovh_row_in = 4'(r);
        ovh_col_in = 6'(c);
        ovh_byte_in = b;
        @(posedge clk_in);
        #1;
        ovh_valid_in = 1'b0;
        ovh_byte_in = ~b;
        check({31'h0, dcc_valid_out}, {31'h0, b[0]});
        if (b[0]) check({24'h0, dcc_data_out}, {24'h0, b});
    endtask : ovh
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : close_out

    // ****************************************
    // clock, watchdog and test sequence
    // ****************************************
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    initial begin
        #(100 * 40000);
        failures++;
        close_out();
    end
    initial begin
        {rst_in, low_rate_select_in, status_clr_in, ovh_valid_in, ovh_is_dcc_in} = 5'b10000;
        {ovh_is_j1_in, ovh_row_in, ovh_col_in, ovh_byte_in} = 19'h0;
        {chk_valid_in, cell_to_fifo_in, idle_drop_in, unassigned_drop_in} = 4'h0;
        {hdr_one_err_in, hdr_multi_err_in, drop_cfg_in} = 4'h0;
        {b1_err_bits_in, b2_err_bits_in, b3_err_bits_in, z2_febe_in, g1_byte_in} = 40'h0;
        exp_status = 12'h000;
        rnd = 32'h9d86;
        repeat (10) @(posedge clk_in);
        #1;
        rst_in = 1'b0;
        check_all();
        $display("reset values done");
        repeat (300) begin
            rnd = lfsr(rnd);
            drive(rnd);
        end
        drive(32'h0);
        check_all();
        check_all();
        $display("event counting done");
        for (int i = 0; i < 12; i++) begin
            for (int k = 0; k < (rx_mon_pkg::CNT_LONG[i] ? 3 : 2); k++) begin
                host.write_byte(rx_mon_pkg::CNT_BASE + rx_mon_pkg::CNT_OFS[i] + 10'(k), 8'hff);
            end
            exp_cnt[i] = rx_mon_pkg::CNT_LONG[i] ? 32'hffffff : 32'hffff;
            drive(bump_tab[i]);
            drive(32'h0);
            check_all();
            @(posedge clk_in);
            #1;
            status_clr_in = 1'b1;
            @(posedge clk_in);
            #1;
            status_clr_in = 1'b0;
            exp_status = 12'h000;
            check({31'h0, irq_out}, 32'h0);
        end
        $display("rollover done");
        for (int k = 0; k < 24; k++) begin
            rnd = lfsr(rnd);
            row = int'(rnd[15:0]) % 9;
            col = int'(rnd[31:16]) % (k >= 12 ? 10 : 40);
            ovh(row, col, k >= 12, 1'b0, rnd[7:0]);
            exp_ram[int'(rx_mon_pkg::RAM_BASE) + row * 40 + (k >= 12 ? col * 4 : col)] = rnd[7:0];
        end
        foreach (exp_ram[ad]) begin
            host.read_byte(10'(ad), d);
            check({24'h0, d}, {24'h0, exp_ram[ad]});
        end
        $display("overhead storage done");
        for (int k = 0; k < 65; k++) ovh(0, 36, 1'b0, 1'b1, 8'(k * 2));
        for (int k = 0; k < 64; k++) begin
            host.read_byte(rx_mon_pkg::TRACE_BASE + 10'(k), d);
            check({24'h0, d}, 32'(k == 0 ? 128 : k * 2));
        end
        $display("path trace done");
        close_out();
    end
endmodule : tb
